// ===== pkg/bypass_host_pkg.sv
// Constants and types shared by the bypass program host controller
`default_nettype none
package bypass_host_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 10;
	localparam int WRITE_PULSE_NS = 40;
	localparam int READ_ACCESS_NS = 80;
	localparam int SUSPEND_LATENCY_NS = 40000;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 16;

	// ****************************************
	// Bus widths and command codes
	// ****************************************
	localparam int ADDR_W = 23;
	localparam int DATA_W = 16;
	localparam int SECTOR_LSB = 15;
	localparam logic [7:0] CMD_WORD = 8'ha0;
	localparam logic [7:0] CMD_BUFFER = 8'h25;
	localparam logic [7:0] CMD_CONFIRM = 8'h29;
	localparam logic [7:0] CMD_SUSPEND = 8'h51;
	localparam logic [7:0] CMD_SUSPEND_OLD = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'h50;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 23'h000555;
	localparam logic [DATA_W-1:0] MAX_WORD_COUNT = 16'h007f;
	localparam int READY_BIT = 7;
	localparam int HANG_BIT = 4;
	localparam logic [8:0] WC_EMPTY = 9'h1ff;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		OP_READ, OP_STATUS, OP_WORD, OP_BUF_START, OP_BUF_DATA,
		OP_BUF_CONFIRM, OP_SUSPEND, OP_RESUME, OP_RESET
	} op_t;

	typedef struct packed {
		op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} cmd_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dqOut;
		logic dqOe;
		logic ceN;
		logic weN;
		logic oeN;
	} pins_t;

	// Host-side picture of the device state
	typedef enum logic [2:0] {
		BYPASS_BASE, BUFFER_LOAD, BUFFER_DATA, PROGRAMMING, SUSPEND_REQUEST,
		PROGRAM_HELD
	} dev_state_t;
endpackage : bypass_host_pkg
`default_nettype wire

// ===== verilog/bypass_program_host.sv
// Host controller driving unlock-bypass program, buffer and suspend sequences
`default_nettype none

// Notes on behaviour
// - Under erase hold, program held: reads, status keep state; resume returns to programming.
// - Status entry is 70h at 555h; it changes the state only in programming, where a ready status read without the hang bit returns to base.
// - Program held: reads and status keep state; resume returns to programming.
// - Confirm 29h only when count reached -1 and sector matches.
// - Suspend while busy enters request, held after the suspend latency.
// - Host uses enhanced suspend 51h and resume 50h only.
// - Hang with ready bit set: reads keep state, F0h returns to idle.
module bypass_program_host #(
	parameter int SUSPEND_LATENCY_CYC = (bypass_host_pkg::SUSPEND_LATENCY_NS
		+ bypass_host_pkg::CLK_NS - 1) / bypass_host_pkg::CLK_NS
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic cmdValid,
	input wire bypass_host_pkg::cmd_t cmd,
	input wire logic eraseHeld,
	input wire logic [bypass_host_pkg::DATA_W-1:0] dqIn,
	output bypass_host_pkg::pins_t pins,
	output logic cmdReady,
	output logic cmdDone,
	output logic cmdRefused,
	output logic [bypass_host_pkg::DATA_W-1:0] readData,
	output bypass_host_pkg::dev_state_t devState,
	output logic nestedErase,
	output logic hang
);
	typedef enum {B_IDLE, B_SETUP, B_PULSE, B_HOLD, B_READ} bus_t;

	bus_t bus_q;
	bypass_host_pkg::pins_t pins_q;
	bypass_host_pkg::dev_state_t state_q, state_d;
	logic [bypass_host_pkg::CNT_W-1:0] cnt_q, latCnt_q;
	logic [bypass_host_pkg::ADDR_W-1:0] a0_q, a1_q, rdAddr_q, a0_d, a1_d, rdAddr_d, sector_q;
	logic [bypass_host_pkg::DATA_W-1:0] d0_q, d1_q, d0_d, d1_d, rdData_q;
	logic [1:0] nWr_q, nWr_d;
	logic rd_q, rd_d, rdStatus_q, rdStatus_d;
	logic ready_q, done_q, refused_q, nested_q, hang_q, devReady_q;
	logic [8:0] wordsLeft_q;
	logic accept, legal, autoPoll, start, statusEval, sectorOk;

	assign accept = cmdValid && ready_q;
	assign autoPoll = ready_q && !cmdValid && state_q == bypass_host_pkg::PROGRAMMING && !hang_q;
	assign start = (accept && legal) || autoPoll;
	assign statusEval = bus_q == B_READ && cnt_q == '0 && rdStatus_q;
	assign sectorOk = cmd.addr[bypass_host_pkg::ADDR_W-1:bypass_host_pkg::SECTOR_LSB]
		== sector_q[bypass_host_pkg::ADDR_W-1:bypass_host_pkg::SECTOR_LSB];

	// ****************************************
	// Command decode
	// ****************************************
	// Work out legality, bus cycles and the device state each command leads to
	always_comb begin
		legal = 1'b0;
		state_d = state_q;
		nWr_d = 2'd1;
		rd_d = 1'b0;
		rdStatus_d = 1'b0;
		a0_d = cmd.addr;
		d0_d = cmd.data;
		a1_d = cmd.addr;
		d1_d = cmd.data;
		rdAddr_d = cmd.addr;
		if (autoPoll || cmd.op == bypass_host_pkg::OP_STATUS) begin
			// Status entry is legal in every state; only a ready, non-hung status read in programming moves it, to base
			legal = 1'b1;
			a0_d = bypass_host_pkg::STATUS_ADDR;
			d0_d = {8'h00, bypass_host_pkg::CMD_STATUS};
			rd_d = 1'b1;
			rdStatus_d = 1'b1;
		end else begin
			case (cmd.op)
				bypass_host_pkg::OP_READ: begin
					// Reads keep every state, held ones included
					legal = 1'b1;
					nWr_d = 2'd0;
					rd_d = 1'b1;
				end
				bypass_host_pkg::OP_WORD: begin
					// Entry then one data write starts programming
					legal = state_q == bypass_host_pkg::BYPASS_BASE;
					nWr_d = 2'd2;
					d0_d = {8'h00, bypass_host_pkg::CMD_WORD};
					state_d = bypass_host_pkg::PROGRAMMING;
				end
				bypass_host_pkg::OP_BUF_START: begin
					// An oversize count would only earn a program error
					legal = state_q == bypass_host_pkg::BYPASS_BASE
						&& cmd.data <= bypass_host_pkg::MAX_WORD_COUNT;
					nWr_d = 2'd2;
					d0_d = {8'h00, bypass_host_pkg::CMD_BUFFER};
					state_d = bypass_host_pkg::BUFFER_LOAD;
				end
				bypass_host_pkg::OP_BUF_DATA: begin
					// Data outside the entered sector or past the count is refused
					legal = (state_q == bypass_host_pkg::BUFFER_LOAD
						|| state_q == bypass_host_pkg::BUFFER_DATA)
						&& sectorOk && wordsLeft_q != bypass_host_pkg::WC_EMPTY;
					state_d = bypass_host_pkg::BUFFER_DATA;
				end
				bypass_host_pkg::OP_BUF_CONFIRM: begin
					legal = state_q == bypass_host_pkg::BUFFER_DATA && sectorOk
						&& wordsLeft_q == bypass_host_pkg::WC_EMPTY;
					d0_d = {8'h00, bypass_host_pkg::CMD_CONFIRM};
					state_d = bypass_host_pkg::PROGRAMMING;
				end
				bypass_host_pkg::OP_SUSPEND: begin
					// Enhanced code only; the legacy form risks nested loops
					legal = state_q == bypass_host_pkg::PROGRAMMING && !devReady_q;
					d0_d = {8'h00, bypass_host_pkg::CMD_SUSPEND};
					state_d = bypass_host_pkg::SUSPEND_REQUEST;
				end
				bypass_host_pkg::OP_RESUME: begin
					legal = state_q == bypass_host_pkg::PROGRAM_HELD;
					d0_d = {8'h00, bypass_host_pkg::CMD_RESUME};
					state_d = bypass_host_pkg::PROGRAMMING;
				end
				bypass_host_pkg::OP_RESET: begin
					// Only a hung program may be reset here
					legal = state_q == bypass_host_pkg::PROGRAMMING && hang_q;
					d0_d = {8'h00, bypass_host_pkg::CMD_RESET};
					state_d = bypass_host_pkg::BYPASS_BASE;
				end
				default: begin
					legal = 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Bus sequencer and pins
	// ****************************************
	// Runs write cycles then an optional read; pins change only here
	always_ff @(posedge clock) begin
		if (!rstn) begin
			bus_q <= B_IDLE;
			pins_q <= '{addr: '0, dqOut: '0, dqOe: 1'b0, ceN: 1'b1, weN: 1'b1, oeN: 1'b1};
			cnt_q <= '0;
			nWr_q <= 2'd0;
			rd_q <= 1'b0;
			rdStatus_q <= 1'b0;
			{a0_q, a1_q, rdAddr_q, d0_q, d1_q, rdData_q} <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (bus_q)
				B_IDLE: begin
					if (start) begin
						{a0_q, d0_q, a1_q, d1_q, rdAddr_q} <= {a0_d, d0_d, a1_d, d1_d, rdAddr_d};
						nWr_q <= nWr_d;
						rd_q <= rd_d;
						rdStatus_q <= rdStatus_d;
						bus_q <= (nWr_d != 2'd0) ? B_SETUP : B_READ;
						pins_q.addr <= (nWr_d != 2'd0) ? a0_d : rdAddr_d;
						pins_q.dqOut <= d0_d;
						pins_q.dqOe <= nWr_d != 2'd0;
						pins_q.ceN <= 1'b0;
						pins_q.oeN <= nWr_d != 2'd0;
						cnt_q <= bypass_host_pkg::CNT_W'(bypass_host_pkg::READ_ACCESS_CYC - 1);
					end
				end
				B_SETUP: begin
					pins_q.weN <= 1'b0;
					cnt_q <= bypass_host_pkg::CNT_W'(bypass_host_pkg::WRITE_PULSE_CYC - 1);
					bus_q <= B_PULSE;
				end
				B_PULSE: begin
					if (cnt_q == '0) begin
						pins_q.weN <= 1'b1;
						bus_q <= B_HOLD;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				B_HOLD: begin
					// A one-cycle gap keeps address and data steady past the rising strobe
					if (nWr_q == 2'd2) begin
						nWr_q <= 2'd1;
						pins_q.addr <= a1_q;
						pins_q.dqOut <= d1_q;
						bus_q <= B_SETUP;
					end else if (rd_q) begin
						pins_q.addr <= rdAddr_q;
						pins_q.dqOe <= 1'b0;
						pins_q.oeN <= 1'b0;
						cnt_q <= bypass_host_pkg::CNT_W'(bypass_host_pkg::READ_ACCESS_CYC - 1);
						bus_q <= B_READ;
					end else begin
						pins_q.dqOe <= 1'b0;
						pins_q.ceN <= 1'b1;
						done_q <= 1'b1;
						bus_q <= B_IDLE;
					end
				end
				B_READ: begin
					if (cnt_q == '0) begin
						rdData_q <= dqIn;
						pins_q.ceN <= 1'b1;
						pins_q.oeN <= 1'b1;
						done_q <= 1'b1;
						bus_q <= B_IDLE;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				default: bus_q <= B_IDLE;
			endcase
		end
	end

	// Ready is withheld while the bus works or a suspend settles; a refused
	// suspend must not hold it low, or the port would lock up
	always_ff @(posedge clock) begin
		if (!rstn) begin
			ready_q <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			ready_q <= !start && !(bus_q != B_IDLE && !done_q)
				&& state_q != bypass_host_pkg::SUSPEND_REQUEST;
			refused_q <= accept && !legal;
		end
	end

	// ****************************************
	// Device state picture
	// ****************************************
	// Follows commands, status reads and the suspend latency
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_q <= bypass_host_pkg::BYPASS_BASE;
			nested_q <= 1'b0;
			hang_q <= 1'b0;
			devReady_q <= 1'b1;
			latCnt_q <= '0;
			wordsLeft_q <= '0;
			sector_q <= '0;
		end else begin
			if (accept && legal) begin
				state_q <= state_d;
				if (cmd.op == bypass_host_pkg::OP_WORD || cmd.op == bypass_host_pkg::OP_BUF_START) begin
					nested_q <= eraseHeld;
					sector_q <= cmd.addr;
				end
				if (cmd.op == bypass_host_pkg::OP_BUF_START)
					wordsLeft_q <= cmd.data[8:0];
				if (cmd.op == bypass_host_pkg::OP_BUF_DATA)
					wordsLeft_q <= wordsLeft_q - 9'h001;
				if (state_d == bypass_host_pkg::PROGRAMMING)
					devReady_q <= 1'b0;
				if (cmd.op == bypass_host_pkg::OP_RESET)
					hang_q <= 1'b0;
				if (cmd.op == bypass_host_pkg::OP_SUSPEND)
					latCnt_q <= bypass_host_pkg::CNT_W'(SUSPEND_LATENCY_CYC);
			end else if (state_q == bypass_host_pkg::SUSPEND_REQUEST) begin
				// Held once the worst-case latency has passed
				if (latCnt_q == '0)
					state_q <= bypass_host_pkg::PROGRAM_HELD;
				else
					latCnt_q <= latCnt_q - 1'b1;
			end
			if (statusEval && state_q == bypass_host_pkg::PROGRAMMING) begin
				devReady_q <= dqIn[bypass_host_pkg::READY_BIT];
				if (dqIn[bypass_host_pkg::READY_BIT] && dqIn[bypass_host_pkg::HANG_BIT])
					hang_q <= 1'b1;
				else if (dqIn[bypass_host_pkg::READY_BIT])
					state_q <= bypass_host_pkg::BYPASS_BASE;
			end
		end
	end

	assign pins = pins_q;
	assign cmdReady = ready_q;
	assign cmdDone = done_q;
	assign cmdRefused = refused_q;
	assign readData = rdData_q;
	assign devState = state_q;
	assign nestedErase = nested_q;
	assign hang = hang_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence s_statusTaken;
		accept && cmd.op == bypass_host_pkg::OP_STATUS;
	endsequence
	sequence s_statusCycle;
		!pins.weN && pins.addr == bypass_host_pkg::STATUS_ADDR
			&& pins.dqOut[7:0] == bypass_host_pkg::CMD_STATUS;
	endsequence

	a_status_keeps: assert property (s_statusTaken |=> devState == $past(devState))
		else $error("status entry moved the state");
	a_status_pins: assert property (s_statusTaken |-> ##2 s_statusCycle)
		else $error("status entry not written as 70h at 555h");
	a_no_legacy: assert property (!pins.weN |-> pins.dqOut[7:0] != bypass_host_pkg::CMD_SUSPEND_OLD)
		else $error("legacy suspend code issued");
	a_resume_prog: assert property (accept && cmd.op == bypass_host_pkg::OP_RESUME
		&& devState == bypass_host_pkg::PROGRAM_HELD
		|=> devState == bypass_host_pkg::PROGRAMMING && $stable(nestedErase))
		else $error("resume did not return to programming");
	a_suspend_settle: assert property (devState == bypass_host_pkg::SUSPEND_REQUEST
		&& latCnt_q == '0 && !(accept && legal)
		|=> devState == bypass_host_pkg::PROGRAM_HELD)
		else $error("suspend request not held after latency");
	a_count_step: assert property (accept && legal && cmd.op == bypass_host_pkg::OP_BUF_DATA
		|=> wordsLeft_q == $past(wordsLeft_q) - 9'h001)
		else $error("buffer count not decremented");
	a_confirm_gate: assert property (accept && cmd.op == bypass_host_pkg::OP_BUF_CONFIRM
		&& wordsLeft_q != bypass_host_pkg::WC_EMPTY |=> cmdRefused && $stable(devState))
		else $error("early confirm accepted");
	a_reset_back: assert property (accept && legal && cmd.op == bypass_host_pkg::OP_RESET
		|=> devState == bypass_host_pkg::BYPASS_BASE && !hang
		&& $stable(nestedErase))
		else $error("reset did not restore the base state");
	a_done_back: assert property (statusEval && devState == bypass_host_pkg::PROGRAMMING
		&& dqIn[bypass_host_pkg::READY_BIT] && !dqIn[bypass_host_pkg::HANG_BIT]
		|=> devState == bypass_host_pkg::BYPASS_BASE)
		else $error("completion did not return to base");
	a_big_count: assert property (accept && cmd.op == bypass_host_pkg::OP_BUF_START
		&& cmd.data > bypass_host_pkg::MAX_WORD_COUNT |=> cmdRefused)
		else $error("oversize buffer count accepted");
endmodule : bypass_program_host
`default_nettype wire

// ===== verif/flash_model.sv
// Behavioural model of the flash device in unlock-bypass program mode
`default_nettype none
module flash_model (
	input wire logic clock,
	input wire bypass_host_pkg::pins_t pins,
	input wire logic hangMode,
	output logic [15:0] dqIn,
	output logic legacySeen
);
	timeunit 1ns;
	timeprecision 1ps;
	// States: 0 idle, 1 word, 2 load, 3 data, 4 busy, 5 request, 6 held, 7 error
	localparam int PROG_CYC = 300;
	int st = 0;
	int left = 0;
	int slat = 0;
	int wc = 0;
	logic [7:0] sect = 8'h00;
	logic statusNext = 1'b0;
	logic [15:0] lastQ = 16'h0000;
	wire logic [7:0] cb = pins.dqOut[7:0];
	wire logic [7:0] sec = pins.addr[22:15];
	wire logic rdy = (st != 4 && st != 5) || hangMode;
	wire logic [15:0] status = {8'h00, rdy, 2'b00, hangMode && st == 4, 4'h0};
	logic legacy = 1'b0;
	assign legacySeen = legacy;

	// ****************************************
	// Write cycles, decoded as the strobe rises
	// ****************************************
	always @(posedge pins.weN) begin
		if (!pins.ceN && cb == 8'h70 && pins.addr == 23'h000555) begin
			statusNext <= 1'b1;
		end else if (!pins.ceN) begin
			case (st)
				0: begin
					st <= (cb == 8'ha0) ? 1 : (cb == 8'h25) ? 2 : 0;
					sect <= sec;
				end
				1: st <= 4;
				2: begin
					wc <= int'(pins.dqOut);
					st <= (pins.dqOut > 16'h007f || sec != sect) ? 7 : 3;
				end
				3: begin
					// Count runs one past zero so the confirm lands at -1
					if (wc == -1) st <= (cb == 8'h29 && sec == sect) ? 4 : 7;
					else if (sec != sect) st <= 7;
					else wc <= wc - 1;
				end
				4: begin
					if ((cb == 8'h51 || cb == 8'hb0) && !hangMode) st <= 5;
					if (cb == 8'hf0 && hangMode) st <= 0;
					if (cb == 8'hb0) legacy <= 1'b1;
				end
				6: begin
					if (cb == 8'h50 || cb == 8'h30) st <= 4;
					if (cb == 8'h30) legacy <= 1'b1;
				end
				default: st <= st;
			endcase
			if (st == 1 || st == 3) left <= PROG_CYC;
		end
	end

	// Only the first read after status entry returns status
	always @(posedge pins.oeN) statusNext <= 1'b0;

	// Program progress and suspend latency; a hang never completes
	always @(posedge clock) begin
		lastQ <= dqIn;
		if (st == 4 && !hangMode && left > 0) left <= left - 1;
		if (st == 4 && !hangMode && left == 1) st <= 0;
		slat <= (st == 5) ? slat + 1 : 0;
		if (st == 5 && slat == 5) st <= 6;
	end

	// Released bus shows a changing pattern, never a held value
	assign dqIn = (!pins.ceN && !pins.oeN) ? (statusNext ? status : ~pins.addr[15:0]) : ~lastQ;
endmodule : flash_model
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the bypass program host controller
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic cmdValid = 1'b0;
	bypass_host_pkg::cmd_t cmd = '0;
	logic eraseHeld = 1'b0;
	logic hangMode = 1'b0;
	wire logic [15:0] dqIn;
	bypass_host_pkg::pins_t pins;
	logic cmdReady, cmdDone, cmdRefused, nestedErase, hang, legacySeen, gotRefused;
	logic [15:0] readData;
	bypass_host_pkg::dev_state_t devState;
	int errors = 0;
	int compares = 0;

	always #5 clock = ~clock;

	bypass_program_host #(.SUSPEND_LATENCY_CYC(10)) uut (.clock(clock), .rstn(rstn),
		.cmdValid(cmdValid), .cmd(cmd), .eraseHeld(eraseHeld), .dqIn(dqIn), .pins(pins),
		.cmdReady(cmdReady), .cmdDone(cmdDone), .cmdRefused(cmdRefused),
		.readData(readData), .devState(devState), .nestedErase(nestedErase), .hang(hang));
	flash_model model (.clock(clock), .pins(pins), .hangMode(hangMode), .dqIn(dqIn),
		.legacySeen(legacySeen));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	// Ops and states are given as their position in op_t and dev_state_t
	task automatic run(input int o, input logic [22:0] a, input logic [15:0] d, input int r,
		input int s);
		int n;
		n = 0;
		@(posedge clock);
		cmdValid <= 1'b1;
		cmd <= '{bypass_host_pkg::op_t'(o), a, d};
		// Held until an edge with ready high; auto polls may delay it
		do begin
			@(negedge clock);
			n++;
		end while (cmdReady !== 1'b1 && n < 9000);
		@(posedge clock);
		cmdValid <= 1'b0;
		do begin
			@(negedge clock);
			n++;
		end while (cmdDone !== 1'b1 && cmdRefused !== 1'b1 && n < 9000);
		gotRefused = cmdRefused;
		if (n >= 9000) begin
			check(32'h1, 32'h0);
			results();
		end
		check(gotRefused, r);
		if (s >= 0) check(devState, s);
	endtask : run

	task automatic wait_state(input int s);
		int n;
		n = 0;
		while (devState !== bypass_host_pkg::dev_state_t'(s) && n < 2000) begin
			@(negedge clock);
			n++;
		end
		check(devState, s);
		if (n >= 2000) begin
			results();
		end
	endtask : wait_state

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_word();
		run(1, 23'h000555, 16'h0, 0, 0);
		check(readData, 16'h0080);
		run(2, 23'h012345, 16'h1234, 0, 3);
		run(2, 23'h012345, 16'h1234, 1, 3);
		wait_state(0);
		run(0, 23'h000042, 16'h0, 0, 0);
		check(readData, 16'hffbd);
		$display("t_word done");
	endtask : t_word

	task automatic t_buffer();
		run(3, 23'h018000, 16'h0080, 1, 0);
		run(3, 23'h018000, 16'h0001, 0, 1);
		run(4, 23'h020000, 16'h1111, 1, 1);
		run(4, 23'h018001, 16'h1111, 0, 2);
		run(5, 23'h018000, 16'h0029, 1, 2);
		run(4, 23'h018002, 16'h2222, 0, 2);
		run(4, 23'h018003, 16'h3333, 1, 2);
		run(5, 23'h028000, 16'h0029, 1, 2);
		run(5, 23'h018000, 16'h0029, 0, 3);
		wait_state(0);
		$display("t_buffer done");
	endtask : t_buffer

	// Suspend, hold and resume, plain or under erase hold
	task automatic t_suspend(input logic nested);
		@(posedge clock);
		eraseHeld <= nested;
		run(2, 23'h000100, 16'habcd, 0, 3);
		check(nestedErase, nested);
		run(1, 23'h000555, 16'h0, 0, 3);
		check(readData, 16'h0000);
		run(6, 23'h000000, 16'h0051, 0, -1);
		wait_state(5);
		run(1, 23'h000555, 16'h0, 0, 5);
		run(0, 23'h000200, 16'h0, 0, 5);
		run(8, 23'h000000, 16'h00f0, 1, 5);
		run(7, 23'h000000, 16'h0050, 0, 3);
		wait_state(0);
		check(nestedErase, nested);
		check(legacySeen, 1'b0);
		$display("t_suspend done");
	endtask : t_suspend

	// Hang on timeout, then software reset, plain or under erase hold
	task automatic t_hang(input logic nested);
		@(posedge clock);
		eraseHeld <= nested;
		hangMode <= 1'b1;
		run(2, 23'h000300, 16'h5a5a, 0, 3);
		run(1, 23'h000555, 16'h0, 0, 3);
		check(readData, 16'h0090);
		check(hang, 1'b1);
		run(0, 23'h000300, 16'h0, 0, 3);
		run(8, 23'h000000, 16'h00f0, 0, 0);
		check(nestedErase, nested);
		@(posedge clock);
		hangMode <= 1'b0;
		$display("t_hang done");
	endtask : t_hang

	initial begin
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		repeat (3) @(posedge clock);
		t_word();
		t_buffer();
		t_suspend(1'b0);
		t_suspend(1'b1);
		t_hang(1'b1);
		t_hang(1'b0);
		results();
	end
endmodule : testbench
`default_nettype wire
